// *** bench/i2c_host_model.sv ***
// Behavioural two-wire bus master that stands on the host side of the sensor
`timescale 1ns/100ps
module i2c_host_model (
   input wire logic mclk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_rel_o,
   output logic sda_rel_o
);
   // Half bit of 50 clocks gives a 1000 kHz bus clock
   localparam int HALF = 50;
   logic hung;
   initial begin
      scl_rel_o = 1'b1;
      sda_rel_o = 1'b1;
      hung = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : wait_clk
   // Lines are only ever released or pulled low
   // Released clock may be held low by the target, so wait for it
   task automatic scl_up;
      int n;
      n = 0;
      scl_rel_o <= 1'b1;
      @(posedge mclk_i);
      while (scl_i !== 1'b1 && n < 2000) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 2000) hung = 1'b1;
      wait_clk(HALF);
   endtask : scl_up
   task automatic bit_cycle(input logic b, output logic r);
      wait_clk(5);
      sda_rel_o <= b;
      wait_clk(HALF);
      scl_up();
      r = sda_i;
      scl_rel_o <= 1'b0;
      @(posedge mclk_i);
   endtask : bit_cycle
   task automatic start;
      wait_clk(5);
      sda_rel_o <= 1'b1;
      wait_clk(HALF);
      scl_up();
      sda_rel_o <= 1'b0;
      wait_clk(HALF);
      scl_rel_o <= 1'b0;
      wait_clk(HALF);
   endtask : start
   task automatic stop;
      wait_clk(5);
      sda_rel_o <= 1'b0;
      wait_clk(HALF);
      scl_up();
      sda_rel_o <= 1'b1;
      wait_clk(HALF);
   endtask : stop
   // Eight bits MSB first, then the ninth bit released or driven as ack
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
         output logic ack_n);
      for (int i = 7; i >= 0; i--) bit_cycle(d[i], q[i]);
      bit_cycle(last, ack_n);
   endtask : xfer
endmodule : i2c_host_model

// *** bench/sensor_i2c_pin_interface_bench.sv ***
// Self-checking bench for the sensor two-wire pin interface
`timescale 1ns/100ps
module sensor_i2c_pin_interface_bench;
   logic mclk_i = 1'b0, rst_i = 1'b1, addr_sel_i = 1'b0, hard_reset_n_i = 1'b1;
   logic rx_ready_i = 1'b0, tx_valid_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   sensor_pins_pkg::reading_s reading_i = '0;
   sensor_pins_pkg::limits_s limits_i = '0;
   logic scl_out_o, scl_oe_n_o, sda_out_o, sda_oe_n_o, alarm_o, ready_o, rx_valid_o, tx_ready_o;
   sensor_pins_pkg::rx_byte_s rx_o, got;
   logic scl_rel, sda_rel;
   int n_mismatch = 0, check_count = 0;
   int rx_age = 0, n_stretch = 0, n_tx = 0;
   localparam int RX_HOLD = 200;
   // Open-drain wires with pull-ups
   wire scl_w = scl_rel & (scl_oe_n_o | scl_out_o);
   wire sda_w = sda_rel & (sda_oe_n_o | sda_out_o);
   // Power-up wait outlasts the first start, so the early header meets a busy device
   sensor_i2c_pins #(.POWER_UP_CYCLES(500)) i_sensor_i2c_pins (.mclk_i(mclk_i), .rst_i(rst_i),
      .scl_i(scl_w), .scl_out_o(scl_out_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w),
      .sda_out_o(sda_out_o), .sda_oe_n_o(sda_oe_n_o), .addr_sel_i(addr_sel_i),
      .hard_reset_n_i(hard_reset_n_i), .alarm_o(alarm_o), .ready_o(ready_o), .rx_o(rx_o),
      .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .tx_data_i(tx_data_i),
      .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .reading_i(reading_i),
      .limits_i(limits_i));
   i2c_host_model i_host_model (.mclk_i(mclk_i), .scl_i(scl_w), .sda_i(sda_w),
      .scl_rel_o(scl_rel), .sda_rel_o(sda_rel));
   always #5 mclk_i = ~mclk_i;
   // User side holds each received byte a while so the clock stretch shows on the wire
   always @(posedge mclk_i) begin
      rx_age <= rx_valid_o ? rx_age + 1 : 0;
      rx_ready_i <= rx_valid_o && !rx_ready_i && rx_age >= RX_HOLD;
      if (rx_valid_o && rx_ready_i) got <= rx_o;
      tx_valid_i <= tx_ready_o && !tx_valid_i;
      if (tx_valid_i && tx_ready_o) n_tx++;
      if (scl_rel && !scl_w) n_stretch++;
   end
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   always @(negedge mclk_i) if (!sda_oe_n_o || !scl_oe_n_o) check(9'({sda_out_o, scl_out_o}), 9'h0);
   task automatic tally_and_finish;
      if (i_host_model.hung) n_mismatch++;
      if (n_mismatch == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic xf(input logic [7:0] d, input logic last, output logic [7:0] q, output logic a);
      i_host_model.xfer(d, last, q, a);
      if (i_host_model.hung) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : xf
   task automatic wait_ready;
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 1000) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 1000) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wait_ready
   // Header sent before power-up wait ends gets no ack
   task automatic t_early;
      logic [7:0] q;
      logic ak;
      check(9'(ready_o), 9'h0);
      i_host_model.start();
      xf({sensor_pins_pkg::ADDR_STRAP_LOW, 1'b0}, 1'b1, q, ak);
      check(9'(ak), 9'h1);
      i_host_model.stop();
   endtask : t_early
   // Strap level picks the answered address; two back-to-back bytes written
   task automatic t_addr(input logic strap, input logic [6:0] a, input logic hit);
      logic [7:0] q;
      logic ak;
      int n0;
      n0 = n_stretch;
      addr_sel_i <= strap;
      i_host_model.start();
      xf({a, 1'b0}, 1'b1, q, ak);
      check(9'(ak), 9'(!hit));
      if (hit) begin
         xf(8'ha5, 1'b1, q, ak);
         check(got, 9'h14b);
         xf(8'h5a, 1'b1, q, ak);
         check(got, 9'h0b4);
         check(9'(n_stretch > n0), 9'h1);
      end
      i_host_model.stop();
   endtask : t_addr
   // Two bytes read, the first acked by the master; user answers each tx_ready_o
   task automatic t_read;
      logic [7:0] q;
      logic ak;
      int n0;
      n0 = n_tx;
      tx_data_i <= 8'h3c;
      i_host_model.start();
      xf({sensor_pins_pkg::ADDR_STRAP_HIGH, 1'b1}, 1'b1, q, ak);
      check(9'(ak), 9'h0);
      xf(8'hff, 1'b0, q, ak);
      check(9'(q), 9'h03c);
      tx_data_i <= 8'hc3;
      xf(8'hff, 1'b1, q, ak);
      check(9'(q), 9'h0c3);
      check(9'(n_tx - n0), 9'h002);
      i_host_model.stop();
   endtask : t_read
   // Readings inside, above, below and on the limits
   task automatic t_alarm;
      logic [15:0] h[5] = '{16'h4000, 16'h9000, 16'h0fff, 16'h4000, 16'h8000};
      logic [15:0] t[5] = '{16'h4000, 16'h4000, 16'h4000, 16'h8001, 16'h1000};
      logic e[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      limits_i <= {16'h8000, 16'h1000, 16'h8000, 16'h1000};
      for (int i = 0; i < 5; i++) begin
         reading_i <= {h[i], t[i]};
         repeat (3) @(posedge mclk_i);
         check(9'(alarm_o), 9'(e[i]));
      end
   endtask : t_alarm
   // A short low pulse is filtered; a long one resets the core
   task automatic t_hrst;
      hard_reset_n_i <= 1'b0;
      repeat (50) @(posedge mclk_i);
      hard_reset_n_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      check(9'(ready_o), 9'h1);
      hard_reset_n_i <= 1'b0;
      repeat (110) @(posedge mclk_i);
      check(9'(ready_o), 9'h0);
      hard_reset_n_i <= 1'b1;
      wait_ready();
   endtask : t_hrst
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      t_early();
      wait_ready();
      t_addr(1'b0, sensor_pins_pkg::ADDR_STRAP_LOW, 1'b1);
      t_addr(1'b0, sensor_pins_pkg::ADDR_STRAP_HIGH, 1'b0);
      t_addr(1'b1, sensor_pins_pkg::ADDR_STRAP_HIGH, 1'b1);
      t_addr(1'b1, sensor_pins_pkg::ADDR_STRAP_LOW, 1'b0);
      t_read();
      t_alarm();
      t_hrst();
      t_addr(1'b0, sensor_pins_pkg::ADDR_STRAP_LOW, 1'b1);
      tally_and_finish();
   end
endmodule : sensor_i2c_pin_interface_bench

// *** rtl/sensor_i2c_pins.sv ***
// Two-wire target port, address strap, alarm pin and hard reset of the sensor
//
// Notes on behaviour
// - Bus clock from zero to 1000 kHz works; pins are oversampled.
// - Clock is held low while the device waits for data.
// - Up to 400 kHz the fast-mode timing and behaviour hold.
// - Both bus lines are only ever pulled low, never driven high.
// - Address 0x44 with strap low, 0x45 with strap high.
// - Strap is sampled again at every start condition.
// - Header byte: address in upper seven bits, direction in the lowest.
// - Alarm follows latest readings compared against the limit values.
// - Alarm is active high while the alert condition holds.
// - Bus is ignored until power-up or reset reaches idle.
`timescale 1ns/100ps
module sensor_i2c_pins #(
   parameter int POWER_UP_CYCLES = sensor_pins_pkg::POWER_UP_CYC
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   output logic scl_out_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_out_o,
   output logic sda_oe_n_o,
   input wire logic addr_sel_i,
   input wire logic hard_reset_n_i,
   output logic alarm_o,
   output logic ready_o,
   output sensor_pins_pkg::rx_byte_s rx_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire sensor_pins_pkg::reading_s reading_i,
   input wire sensor_pins_pkg::limits_s limits_i
);
   logic [sensor_pins_pkg::LANES-1:0] pin_meta;
   logic [sensor_pins_pkg::LANES-1:0] pin_sync;
   logic scl_prev;
   logic sda_prev;
   logic [7:0] hr_cnt;
   logic hr_active;
   logic [31:0] pu_cnt;
   sensor_pins_pkg::bus_state_e state;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [6:0] dev_addr;
   logic read_dir;
   logic nack;
   logic first_byte;

   // Pins come from outside; two flops before anything looks at them
   always_ff @(posedge mclk_i) begin
      pin_meta <= {hard_reset_n_i, addr_sel_i, sda_i, scl_i};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[sensor_pins_pkg::LANE_SCL];
      sda_prev <= pin_sync[sensor_pins_pkg::LANE_SDA];
   end

   wire scl_s = pin_sync[sensor_pins_pkg::LANE_SCL];
   wire sda_s = pin_sync[sensor_pins_pkg::LANE_SDA];
   wire addr_s = pin_sync[sensor_pins_pkg::LANE_ADDR];
   wire hrst_n_s = pin_sync[sensor_pins_pkg::LANE_HRST];
   // Edge-driven decode: no minimum bus rate, 100x oversampling at top rate
   wire scl_rise = scl_s & ~scl_prev;
   wire scl_fall = ~scl_s & scl_prev;
   wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   wire stop_det = scl_s & scl_prev & ~sda_prev & sda_s;
   wire [6:0] strap_addr = addr_s ? sensor_pins_pkg::ADDR_STRAP_HIGH
                                  : sensor_pins_pkg::ADDR_STRAP_LOW;
   wire addr_match = (shift[7:1] == dev_addr);
   wire last_bit = (bit_cnt == sensor_pins_pkg::BIT_LAST);
   wire hr_long = (hr_cnt == sensor_pins_pkg::RESET_CNT_MAX);
   wire core_rst = rst_i | hr_active;
   wire stretch = (state == sensor_pins_pkg::ST_RD_LOAD) | rx_valid_o;
   wire hum_out = (reading_i.humidity > limits_i.hum_high) |
                  (reading_i.humidity < limits_i.hum_low);
   wire temp_out = (reading_i.temperature > limits_i.temp_high) |
                   (reading_i.temperature < limits_i.temp_low);
   wire alert_cond = hum_out | temp_out;

   // Shorter glitches on the reset pin are filtered out, not obeyed
   always_ff @(posedge mclk_i) begin
      if (rst_i || hrst_n_s) begin
         hr_cnt <= 8'h00;
      end else if (!hr_long) begin
         hr_cnt <= hr_cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hr_active <= 1'b0;
      end else begin
         hr_active <= hr_long & ~hrst_n_s;
      end
   end

   // Power-up wait uses the longest figure so the host never races it
   always_ff @(posedge mclk_i) begin
      if (core_rst) begin
         pu_cnt <= 32'h0;
         ready_o <= 1'b0;
      end else if (!ready_o) begin
         pu_cnt <= pu_cnt + 32'h1;
         ready_o <= (pu_cnt == 32'(POWER_UP_CYCLES - 1));
      end
   end

   always_ff @(posedge mclk_i) begin
      if (core_rst) begin
         alarm_o <= 1'b0;
      end else begin
         alarm_o <= alert_cond;
      end
   end

   // Output levels are constant low; only the enables move
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         scl_out_o <= 1'b0;
         sda_out_o <= 1'b0;
      end else begin
         scl_out_o <= 1'b0;
         sda_out_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (core_rst) begin
         scl_oe_n_o <= 1'b1;
         tx_ready_o <= 1'b0;
      end else begin
         scl_oe_n_o <= ~stretch;
         tx_ready_o <= (state == sensor_pins_pkg::ST_RD_LOAD) & ~tx_valid_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (core_rst) begin
         state <= sensor_pins_pkg::ST_IDLE;
         shift <= 8'h00;
         bit_cnt <= sensor_pins_pkg::BIT_NONE;
         dev_addr <= sensor_pins_pkg::ADDR_STRAP_LOW;
         read_dir <= 1'b0;
         nack <= 1'b0;
         first_byte <= 1'b0;
         sda_oe_n_o <= 1'b1;
         rx_valid_o <= 1'b0;
         rx_o <= '0;
      end else begin
         if (rx_valid_o && rx_ready_i) begin
            rx_valid_o <= 1'b0;
         end
         if (stop_det) begin
            state <= sensor_pins_pkg::ST_IDLE;
            sda_oe_n_o <= 1'b1;
         end else if (start_det && ready_o) begin
            state <= sensor_pins_pkg::ST_ADDR;
            bit_cnt <= sensor_pins_pkg::BIT_NONE;
            dev_addr <= strap_addr;
            sda_oe_n_o <= 1'b1;
         end else begin
            case (state)
               sensor_pins_pkg::ST_ADDR: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && last_bit) begin
                     if (addr_match) begin
                        state <= sensor_pins_pkg::ST_ADDR_ACK;
                        sda_oe_n_o <= 1'b0;
                        read_dir <= shift[0];
                     end else begin
                        state <= sensor_pins_pkg::ST_IDLE;
                     end
                  end
               end
               sensor_pins_pkg::ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n_o <= 1'b1;
                     bit_cnt <= sensor_pins_pkg::BIT_NONE;
                     first_byte <= 1'b1;
                     state <= read_dir ? sensor_pins_pkg::ST_RD_LOAD
                                       : sensor_pins_pkg::ST_WR_BYTE;
                  end
               end
               sensor_pins_pkg::ST_WR_BYTE: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && last_bit) begin
                     rx_o <= '{data: shift, first: first_byte};
                     rx_valid_o <= 1'b1;
                     sda_oe_n_o <= 1'b0;
                     state <= sensor_pins_pkg::ST_WR_ACK;
                  end
               end
               sensor_pins_pkg::ST_WR_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n_o <= 1'b1;
                     bit_cnt <= sensor_pins_pkg::BIT_NONE;
                     first_byte <= 1'b0;
                     state <= sensor_pins_pkg::ST_WR_BYTE;
                  end
               end
               sensor_pins_pkg::ST_RD_LOAD: begin
                  if (tx_valid_i) begin
                     shift <= tx_data_i;
                     sda_oe_n_o <= tx_data_i[7];
                     bit_cnt <= sensor_pins_pkg::BIT_FIRST;
                     state <= sensor_pins_pkg::ST_RD_BYTE;
                  end
               end
               sensor_pins_pkg::ST_RD_BYTE: begin
                  if (scl_fall && last_bit) begin
                     sda_oe_n_o <= 1'b1;
                     state <= sensor_pins_pkg::ST_RD_ACK;
                  end else if (scl_fall) begin
                     shift <= {shift[6:0], 1'b0};
                     sda_oe_n_o <= shift[6];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               sensor_pins_pkg::ST_RD_ACK: begin
                  if (scl_rise) begin
                     nack <= sda_s;
                  end else if (scl_fall) begin
                     state <= nack ? sensor_pins_pkg::ST_IDLE : sensor_pins_pkg::ST_RD_LOAD;
                  end
               end
               default: begin
                  state <= sensor_pins_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // Checks
   a_scl_low_only: assert property (@(posedge mclk_i) disable iff (rst_i)
      !scl_oe_n_o |-> !scl_out_o) else $error("scl driven high");
   a_sda_low_only: assert property (@(posedge mclk_i) disable iff (rst_i)
      !sda_oe_n_o |-> !sda_out_o) else $error("sda driven high");
   a_addr_strap_pick: assert property (@(posedge mclk_i) disable iff (core_rst)
      (start_det && ready_o && !stop_det) |=> dev_addr == ($past(addr_s)
      ? sensor_pins_pkg::ADDR_STRAP_HIGH : sensor_pins_pkg::ADDR_STRAP_LOW))
      else $error("wrong strap address");
   a_addr_held_frame: assert property (@(posedge mclk_i) disable iff (core_rst)
      (state != sensor_pins_pkg::ST_IDLE && !start_det) |=> $stable(dev_addr))
      else $error("address changed mid transaction");
   a_foreign_no_ack: assert property (@(posedge mclk_i) disable iff (core_rst)
      $rose(state == sensor_pins_pkg::ST_ADDR_ACK) |-> $past(shift[7:1]) == dev_addr)
      else $error("acked foreign address");
   a_read_dir_sel: assert property (@(posedge mclk_i) disable iff (core_rst)
      (state == sensor_pins_pkg::ST_ADDR_ACK && scl_fall && read_dir && !stop_det
       && !start_det) |=> state == sensor_pins_pkg::ST_RD_LOAD)
      else $error("direction bit ignored");
   a_read_stretch: assert property (@(posedge mclk_i) disable iff (core_rst)
      (state == sensor_pins_pkg::ST_RD_LOAD) |=> !scl_oe_n_o)
      else $error("no clock stretch while loading");
   a_write_stretch: assert property (@(posedge mclk_i) disable iff (core_rst)
      rx_valid_o |=> !scl_oe_n_o)
      else $error("no clock stretch while byte pending");
   a_idle_until_ready: assert property (@(posedge mclk_i) disable iff (core_rst)
      !ready_o |-> state == sensor_pins_pkg::ST_IDLE)
      else $error("bus served before idle");
   a_alarm_tracks: assert property (@(posedge mclk_i) disable iff (core_rst)
      ##1 alarm_o == $past(alert_cond)) else $error("alarm lags readings");
   a_reset_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(hr_active) |-> $past(!hrst_n_s, 1) && $past(!hrst_n_s, 2))
      else $error("reset taken from glitch");
   c_write_byte: cover property (@(posedge mclk_i) $rose(rx_valid_o));
   c_read_byte: cover property (@(posedge mclk_i) tx_valid_i && tx_ready_o);
   c_foreign_addr: cover property (@(posedge mclk_i)
      state == sensor_pins_pkg::ST_ADDR && scl_fall && last_bit && !addr_match);
endmodule : sensor_i2c_pins

// *** rtl/sensor_pins_pkg.sv ***
// Shared constants and carriers for the sensor pin interface
package sensor_pins_pkg;
   // Bus addresses chosen by the address strap
   localparam logic [6:0] ADDR_STRAP_LOW = 7'h44;
   localparam logic [6:0] ADDR_STRAP_HIGH = 7'h45;
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam logic [3:0] BIT_NONE = 4'h0;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_MIN_NS = 1000;
   localparam int RESET_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWER_UP_MAX_US = 1;
   localparam int POWER_UP_CYC = POWER_UP_MAX_US * 1000 * 1000 / CLK_PERIOD_NS;
   localparam logic [7:0] RESET_CNT_MAX = 8'(RESET_CYC);
   // Synchroniser lane positions
   localparam int LANE_SCL = 0;
   localparam int LANE_SDA = 1;
   localparam int LANE_ADDR = 2;
   localparam int LANE_HRST = 3;
   localparam int LANES = 4;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_LOAD, ST_RD_BYTE, ST_RD_ACK
   } bus_state_e;

   typedef struct packed {
      logic [7:0] data;
      logic first;
   } rx_byte_s;

   typedef struct packed {
      logic [15:0] humidity;
      logic [15:0] temperature;
   } reading_s;

   typedef struct packed {
      logic [15:0] hum_high;
      logic [15:0] hum_low;
      logic [15:0] temp_high;
      logic [15:0] temp_low;
   } limits_s;
endpackage : sensor_pins_pkg
